//--- verilog/sscd_host.sv
// host sequencer that issues secure sector commands on flash pins
// assumes the flash samples address and data on the rising edge of write enable
`timescale 1ns/100ps
module sscd_host #(
  parameter int AW = 24,
  parameter int DW = 16
) (
  input  wire logic          I_CORE_CLK,
  input  wire logic          I_RST_B,
  input  wire logic          I_REQ_VALID,
  output logic               O_REQ_READY,
  input  wire logic [1:0]    I_REQ_CMD,
  input  wire logic [AW-1:0] I_REQ_BASE,
  input  wire logic [AW-1:0] I_REQ_ADDR,
  input  wire logic [DW-1:0] I_REQ_DATA,
  output logic               O_DONE,
  output logic               O_ERR,
  output logic [DW-1:0]      O_RD_DATA,
  output logic               O_SECURE_MODE,
  output logic [AW-1:0]      O_FL_ADDR,
  output logic [DW-1:0]      O_FL_DQ,
  output logic               O_FL_DQ_OE,
  input  wire logic [DW-1:0] I_FL_DQ,
  output logic               O_FL_CE_B,
  output logic               O_FL_WE_B,
  output logic               O_FL_OE_B
);
  import sscd_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_WLOW, ST_WHIGH, ST_RLOW, ST_FIN} sscd_state_t;

  sscd_state_t   state_ff;
  logic [1:0]    cmd_ff;
  logic [AW-1:0] base_ff;
  logic [AW-1:0] addr_ff;
  logic [DW-1:0] data_ff;
  logic [2:0]    cyc_ff;
  logic [3:0]    cnt_ff;
  logic [1:0]    mode_ff;
  logic          err_ff;
  logic [2:0]    last_cyc;
  logic          bad_req;

  // ***************************************************************
  // request decode
  // ***************************************************************
  assign O_REQ_READY = (state_ff == ST_IDLE);
  // secure region reads are limited to 256 words in secure mode
  assign bad_req = ((I_REQ_CMD == CMD_PROGRAM) && !mode_ff[0]) ||
                   ((I_REQ_CMD == CMD_PROGRAM) && (I_REQ_ADDR < CUSTOMER_FIRST)) || // R9
                   ((I_REQ_CMD == CMD_PROGRAM || I_REQ_CMD == CMD_READ) && mode_ff[0] &&
                    (I_REQ_ADDR >= SECURE_WORDS)); // R9
  always_comb begin
    unique case (cmd_ff)
      CMD_ENTER:   last_cyc = 3'h2;
      CMD_PROGRAM: last_cyc = 3'h3;
      CMD_EXIT:    last_cyc = 3'h3;
      CMD_READ:    last_cyc = 3'h0;
    endcase
  end

  // ***************************************************************
  // write cycle sequence
  // ***************************************************************
  always_comb begin
    O_FL_ADDR = base_ff + OFS_UNLOCK1; // R1
    O_FL_DQ   = DAT_UNLOCK1; // R1
    unique case (cyc_ff)
      3'h0: begin
        O_FL_ADDR = (cmd_ff == CMD_READ) ? base_ff + addr_ff : base_ff + OFS_UNLOCK1; // R7
        O_FL_DQ   = DAT_UNLOCK1; // R1
      end
      3'h1: begin
        O_FL_ADDR = base_ff + OFS_UNLOCK2; // R2
        O_FL_DQ   = DAT_UNLOCK2; // R2
      end
      3'h2: begin
        O_FL_ADDR = base_ff + OFS_UNLOCK1;
        O_FL_DQ   = (cmd_ff == CMD_ENTER) ? DAT_ENTER : // R3
                    (cmd_ff == CMD_EXIT)  ? DAT_EXIT : DAT_PROG_SETUP; // R5 R4
      end
      3'h3: begin
        O_FL_ADDR = (cmd_ff == CMD_EXIT) ? base_ff + OFS_EXIT4 : base_ff + addr_ff; // R6 R4
        O_FL_DQ   = (cmd_ff == CMD_EXIT) ? DAT_EXIT4 : data_ff; // R6 R4
      end
      default: begin
        O_FL_ADDR = base_ff;
        O_FL_DQ   = DAT_EXIT4;
      end
    endcase
  end

  // ***************************************************************
  // pin strobe decode
  // ***************************************************************
  // address and data stay driven through the high phase so the device
  // latches settled values on the rising write strobe
  always_comb begin
    O_FL_CE_B  = 1'b1;
    O_FL_WE_B  = 1'b1;
    O_FL_OE_B  = 1'b1;
    O_FL_DQ_OE = 1'b0;
    unique case (state_ff)
      ST_WLOW: begin
        O_FL_CE_B  = 1'b0;
        O_FL_WE_B  = 1'b0;
        O_FL_DQ_OE = 1'b1;
      end
      ST_WHIGH: begin
        O_FL_CE_B  = 1'b0;
        O_FL_DQ_OE = 1'b1;
      end
      ST_RLOW: begin
        O_FL_CE_B = 1'b0;
        O_FL_OE_B = 1'b0;
      end
      default: begin
        O_FL_CE_B = 1'b1;
      end
    endcase
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state_ff <= ST_IDLE;
      cyc_ff   <= 3'h0;
      cnt_ff   <= 4'h0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          cyc_ff <= 3'h0;
          if (I_REQ_VALID) begin
            if (bad_req) begin
              state_ff <= ST_FIN;
            end else if (I_REQ_CMD == CMD_READ) begin
              state_ff <= ST_RLOW;
              cnt_ff   <= RD_ACC_CYC;
            end else begin
              state_ff <= ST_WLOW;
              cnt_ff   <= WE_LOW_CYC;
            end
          end
        end
        ST_WLOW: begin
          if (cnt_ff <= 4'h1) begin
            state_ff <= ST_WHIGH;
            cnt_ff   <= WE_HIGH_CYC;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        ST_WHIGH: begin
          if (cnt_ff > 4'h1) begin
            cnt_ff <= cnt_ff - 4'h1;
          end else if (cyc_ff == last_cyc) begin
            state_ff <= ST_FIN;
          end else begin
            cyc_ff   <= cyc_ff + 3'h1;
            state_ff <= ST_WLOW;
            cnt_ff   <= WE_LOW_CYC;
          end
        end
        ST_RLOW: begin
          if (cnt_ff <= 4'h1) begin
            state_ff <= ST_FIN;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        ST_FIN: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ***************************************************************
  // request capture, read data and mode tracking
  // ***************************************************************
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      cmd_ff  <= CMD_ENTER;
      base_ff <= '0;
      addr_ff <= '0;
      data_ff <= '0;
      err_ff  <= 1'b0;
    end else if (state_ff == ST_IDLE && I_REQ_VALID) begin
      cmd_ff  <= I_REQ_CMD;
      base_ff <= I_REQ_BASE;
      addr_ff <= I_REQ_ADDR;
      data_ff <= I_REQ_DATA;
      err_ff  <= bad_req;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_RD_DATA <= '0;
    end else if (state_ff == ST_RLOW && cnt_ff <= 4'h1) begin
      O_RD_DATA <= I_FL_DQ;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      mode_ff <= MODE_RST; // R8
    end else if (state_ff == ST_FIN && !err_ff) begin
      if (cmd_ff == CMD_ENTER) begin
        mode_ff <= 2'h1; // R3
      end else if (cmd_ff == CMD_EXIT) begin
        mode_ff <= 2'h0; // R6
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_DONE <= 1'b0;
      O_ERR  <= 1'b0;
    end else begin
      O_DONE <= (state_ff == ST_FIN);
      O_ERR  <= (state_ff == ST_FIN) && err_ff;
    end
  end

  assign O_SECURE_MODE = mode_ff[0];
endmodule : sscd_host

//--- pkg/sscd_pkg.sv
// constants for the host-side secure sector command sequencer
// assumes a 16-bit word-addressed parallel flash behind the pins
// Function
// R1: every command opens with data 00aa written at base plus word offset 555; the host's CMD_READ issues no writes.
// R2: the second write of every command puts 0055 at base plus word offset 2aa.
// R3: a third write of 0088 at base plus 555 enters secure sector mode.
// R4: a word is programmed by the two unlock writes, 00a0 at base plus 555, then the data at the target.
// R5: writing 0090 as third cycle after the unlocks starts the exit command.
// R6: exit finishes with 0000 written at base plus offset 000, returning to the normal array.
// R7: in secure mode the device maps the first sector range onto the secure array, other reads hit main array.
// R8: after reset the device is back in normal address space.
// R9: the secure region is 256 words, factory 000-07f and customer 080-0ff, reads beyond are invalid.
// R10: a mismatched write makes the device abandon the sequence without changing mode.
package sscd_pkg;
  // ***************************************************************
  // command encoding
  // ***************************************************************
  localparam logic [1:0]  CMD_ENTER       = 2'h0;
  localparam logic [1:0]  CMD_PROGRAM     = 2'h1;
  localparam logic [1:0]  CMD_EXIT        = 2'h2;
  localparam logic [1:0]  CMD_READ        = 2'h3;
  // ***************************************************************
  // address offsets and data words
  // ***************************************************************
  localparam logic [23:0] OFS_UNLOCK1     = 24'h000555;
  localparam logic [23:0] OFS_UNLOCK2     = 24'h0002aa;
  localparam logic [23:0] OFS_EXIT4       = 24'h000000;
  localparam logic [15:0] DAT_UNLOCK1     = 16'h00aa;
  localparam logic [15:0] DAT_UNLOCK2     = 16'h0055;
  localparam logic [15:0] DAT_ENTER       = 16'h0088;
  localparam logic [15:0] DAT_PROG_SETUP  = 16'h00a0;
  localparam logic [15:0] DAT_EXIT        = 16'h0090;
  localparam logic [15:0] DAT_EXIT4       = 16'h0000;
  localparam logic [23:0] SECURE_WORDS    = 24'h000100;
  localparam logic [23:0] CUSTOMER_FIRST  = 24'h000080;
  // ***************************************************************
  // bus cycle timing in core clocks
  // ***************************************************************
  localparam int          CLK_NS          = 40;
  localparam int          WE_LOW_NS       = 80;
  localparam int          WE_HIGH_NS      = 80;
  localparam int          RD_ACC_NS       = 120;
  localparam logic [3:0]  WE_LOW_CYC      = 4'((WE_LOW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  WE_HIGH_CYC     = 4'((WE_HIGH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  RD_ACC_CYC      = 4'((RD_ACC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [1:0]  MODE_RST        = 2'h0;
endpackage : sscd_pkg

//--- bench/sscd_flash_model.sv
// flash partner model: command decoder, secure array and read path
// assumes writes are taken on the rising edge of write enable
`timescale 1ns/100ps
module sscd_flash_model import sscd_pkg::*; (
  input  wire logic        I_RST_B,
  input  wire logic        I_CE_B,
  input  wire logic        I_WE_B,
  input  wire logic        I_OE_B,
  input  wire logic [23:0] I_ADDR,
  input  wire logic [15:0] I_DQ,
  output logic      [15:0] O_DQ
);
  logic [15:0] sec [256];
  logic [2:0]  step;
  logic        sec_on;
  wire  [15:0] ofs = I_ADDR[15:0];
  wire  [15:0] rd  = (sec_on && ofs < 16'h0100) ? sec[ofs[7:0]] : ofs ^ 16'h5a5a;
  // released bus shows the inverse so a stale value cannot pass
  assign O_DQ = (!I_CE_B && !I_OE_B) ? rd : ~rd;
  initial for (int i = 0; i < 256; i++) sec[i] = 16'hc000 | 16'(i);
  always @(posedge I_WE_B or negedge I_RST_B) begin
    if (!I_RST_B) begin
      step   <= 3'h0;
      sec_on <= 1'b0;
    end else if (!I_CE_B) begin
      step <= 3'h0;
      case (step)
        3'h0: if (ofs == OFS_UNLOCK1[15:0] && I_DQ == DAT_UNLOCK1) step <= 3'h1;
        3'h1: if (ofs == OFS_UNLOCK2[15:0] && I_DQ == DAT_UNLOCK2) step <= 3'h2;
        3'h2: if (ofs == OFS_UNLOCK1[15:0]) begin
          if (I_DQ == DAT_ENTER) sec_on <= 1'b1;
          if (I_DQ == DAT_PROG_SETUP) step <= 3'h3;
          if (I_DQ == DAT_EXIT) step <= 3'h4;
        end
        3'h3: if (sec_on && ofs < 16'h0100) sec[ofs[7:0]] <= I_DQ;
        3'h4: if (ofs == OFS_EXIT4[15:0] && I_DQ == DAT_EXIT4) sec_on <= 1'b0;
        default: step <= 3'h0;
      endcase
    end
  end
endmodule : sscd_flash_model

//--- bench/sscd_host_assertions.sv
// port assertions for the secure sector host sequencer
// assumes it is bound onto sscd_host with default widths
`timescale 1ns/100ps
module sscd_host_assertions import sscd_pkg::*; (
  input wire logic        I_CORE_CLK,
  input wire logic        I_RST_B,
  input wire logic        I_REQ_VALID,
  input wire logic        O_REQ_READY,
  input wire logic        O_DONE,
  input wire logic        O_ERR,
  input wire logic        O_SECURE_MODE,
  input wire logic        O_FL_DQ_OE,
  input wire logic        O_FL_CE_B,
  input wire logic        O_FL_WE_B,
  input wire logic        O_FL_OE_B,
  input wire logic [1:0]  I_REQ_CMD,
  input wire logic [23:0] I_REQ_BASE,
  input wire logic [23:0] I_REQ_ADDR,
  input wire logic [23:0] O_FL_ADDR,
  input wire logic [15:0] I_REQ_DATA,
  input wire logic [15:0] O_FL_DQ
);
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_B);
  wire logic tk = I_REQ_VALID && O_REQ_READY;
  we_width_a: assert property ($fell(O_FL_WE_B) |-> !O_FL_WE_B [*2] ##1 O_FL_WE_B)
    else $error("write strobe width wrong");
  we_qual_a: assert property (!O_FL_WE_B |-> !O_FL_CE_B && O_FL_OE_B && O_FL_DQ_OE)
    else $error("strobes wrong in write");
  wr_hold_a: assert property (!O_FL_WE_B && !$past(O_FL_WE_B) |-> $stable(O_FL_ADDR) && $stable(O_FL_DQ))
    else $error("write bus moved");
  enter_seq_a: assert property (tk && I_REQ_CMD == CMD_ENTER |-> ##1 O_FL_ADDR == $past(I_REQ_BASE) + OFS_UNLOCK1
    && O_FL_DQ == DAT_UNLOCK1 ##4 O_FL_ADDR == $past(I_REQ_BASE, 5) + OFS_UNLOCK2 && O_FL_DQ == DAT_UNLOCK2
    ##4 O_FL_DQ == DAT_ENTER ##5 O_DONE && O_SECURE_MODE) else $error("enter sequence wrong");
  exit_seq_a: assert property (tk && I_REQ_CMD == CMD_EXIT |-> ##9 O_FL_DQ == DAT_EXIT ##4
    O_FL_ADDR == $past(I_REQ_BASE, 13) + OFS_EXIT4 && O_FL_DQ == DAT_EXIT4 ##5 O_DONE && !O_SECURE_MODE)
    else $error("exit sequence wrong");
  prog_seq_a: assert property (tk && I_REQ_CMD == CMD_PROGRAM && O_SECURE_MODE && I_REQ_ADDR >= CUSTOMER_FIRST
    && I_REQ_ADDR < SECURE_WORDS |-> ##9 O_FL_DQ == DAT_PROG_SETUP ##4 O_FL_DQ == $past(I_REQ_DATA, 13) &&
    O_FL_ADDR == $past(I_REQ_BASE, 13) + $past(I_REQ_ADDR, 13) ##5 O_DONE && !O_ERR) else $error("program wrong");
  prog_refuse_a: assert property (tk && I_REQ_CMD == CMD_PROGRAM && !O_SECURE_MODE |->
    ##1 O_FL_CE_B ##1 O_DONE && O_ERR && O_FL_CE_B) else $error("refusal wrong");
  mode_done_a: assert property ($changed(O_SECURE_MODE) |-> O_DONE)
    else $error("mode moved without done");
endmodule : sscd_host_assertions
bind sscd_host sscd_host_assertions u_chk (.*);

//--- bench/tb_secure_sector_cmd_decoder.sv
// self-checking bench for the secure sector host sequencer
// assumes the flash partner model on the pins and the bound checker
`timescale 1ns/100ps
module tb_secure_sector_cmd_decoder;
  import sscd_pkg::*;
  logic        I_CORE_CLK = 1'b0, I_RST_B, I_REQ_VALID = 1'b0;
  logic        O_REQ_READY, O_DONE, O_ERR, O_SECURE_MODE, O_FL_DQ_OE, O_FL_CE_B, O_FL_WE_B, O_FL_OE_B;
  logic [1:0]  I_REQ_CMD = 2'h0;
  logic [23:0] I_REQ_BASE, I_REQ_ADDR = 24'h0, O_FL_ADDR;
  logic [15:0] I_REQ_DATA = 16'h0, I_FL_DQ, O_FL_DQ, O_RD_DATA, a, d;
  logic [18:0] q [$];
  logic [18:0] e;
  integer      seed = 32061;
  int          n_mismatch = 0, total_checks = 0;
  sscd_host dut (
    .I_CORE_CLK    (I_CORE_CLK),
    .I_RST_B       (I_RST_B),
    .I_REQ_VALID   (I_REQ_VALID),
    .O_REQ_READY   (O_REQ_READY),
    .I_REQ_CMD     (I_REQ_CMD),
    .I_REQ_BASE    (I_REQ_BASE),
    .I_REQ_ADDR    (I_REQ_ADDR),
    .I_REQ_DATA    (I_REQ_DATA),
    .O_DONE        (O_DONE),
    .O_ERR         (O_ERR),
    .O_RD_DATA     (O_RD_DATA),
    .O_SECURE_MODE (O_SECURE_MODE),
    .O_FL_ADDR     (O_FL_ADDR),
    .O_FL_DQ       (O_FL_DQ),
    .O_FL_DQ_OE    (O_FL_DQ_OE),
    .I_FL_DQ       (I_FL_DQ),
    .O_FL_CE_B     (O_FL_CE_B),
    .O_FL_WE_B     (O_FL_WE_B),
    .O_FL_OE_B     (O_FL_OE_B)
  );
  sscd_flash_model u_flash (.I_RST_B(I_RST_B), .I_CE_B(O_FL_CE_B), .I_WE_B(O_FL_WE_B), .I_OE_B(O_FL_OE_B),
    .I_ADDR(O_FL_ADDR), .I_DQ(O_FL_DQ_OE ? O_FL_DQ : 16'hzzzz), .O_DQ(I_FL_DQ));
  task automatic chk_flag(input logic [1:0] g, input logic [1:0] x);
    total_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
    end
  endtask : chk_flag
  task automatic chk_word(input logic [15:0] g, input logic [15:0] x);
    total_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
    end
  endtask : chk_word
  // note is {read, err, mode, data}
  task automatic req(input logic [1:0] c, input logic [15:0] o, input logic [15:0] w, input logic [18:0] x);
    @(posedge I_CORE_CLK);
    q.push_back(x);
    I_REQ_VALID <= 1'b1;
    I_REQ_CMD   <= c;
    I_REQ_ADDR  <= {8'h0, o};
    I_REQ_DATA  <= w;
    repeat (40) begin
      @(negedge I_CORE_CLK);
      if (O_REQ_READY === 1'b1) break;
    end
    if (O_REQ_READY !== 1'b1) n_mismatch++;
    @(posedge I_CORE_CLK);
    I_REQ_VALID <= 1'b0;
  endtask : req
  task automatic tally_and_finish();
    if (n_mismatch == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  always @(negedge I_CORE_CLK) begin
    if (O_DONE === 1'b1) begin
      if (q.size() == 0) begin
        n_mismatch++;
        $display("CHECK FAILED t=%0t got %h exp %h", $time, 1'b1, 1'b0);
      end else begin
        e = q.pop_front();
        chk_flag({O_ERR, O_SECURE_MODE}, e[17:16]);
        if (e[18]) chk_word(O_RD_DATA, e[15:0]);
      end
    end
  end
  initial forever #20 I_CORE_CLK = ~I_CORE_CLK;
  initial begin
    repeat (5000) @(posedge I_CORE_CLK);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    I_RST_B    <= 1'b0;
    I_REQ_BASE <= {8'($random(seed)), 16'h0};
    repeat (16) @(posedge I_CORE_CLK);
    I_RST_B <= 1'b1;
    req(CMD_READ, 16'h0010, 16'h0, {3'b100, 16'h0010 ^ 16'h5a5a});
    req(CMD_PROGRAM, 16'h0090, 16'h1234, {3'b010, 16'h0});
    req(CMD_ENTER, 16'h0, 16'h0, {3'b001, 16'h0});
    req(CMD_READ, 16'h0010, 16'h0, {3'b101, 16'hc010});
    req(CMD_PROGRAM, 16'h007f, 16'h1, {3'b011, 16'h0});
    req(CMD_PROGRAM, 16'h0100, 16'h1, {3'b011, 16'h0});
    req(CMD_READ, 16'h0100, 16'h0, {3'b011, 16'h0});
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 16'h0080 : (i == 3) ? 16'h00ff : 16'h0080 | 16'($random(seed) & 'h7f);
      d = 16'($random(seed));
      req(CMD_PROGRAM, a, d, {3'b001, 16'h0});
      req(CMD_READ, a, 16'h0, {3'b101, d});
    end
    req(CMD_EXIT, 16'h0, 16'h0, {3'b000, 16'h0});
    req(CMD_READ, a, 16'h0, {3'b100, a ^ 16'h5a5a});
    req(CMD_ENTER, 16'h0, 16'h0, {3'b001, 16'h0});
    for (int i = 0; i < 40 && q.size() > 0; i++) @(negedge I_CORE_CLK);
    if (q.size() > 0) n_mismatch++;
    @(posedge I_CORE_CLK);
    I_RST_B <= 1'b0;
    repeat (2) @(posedge I_CORE_CLK);
    I_RST_B <= 1'b1;
    req(CMD_READ, 16'h0010, 16'h0, {3'b100, 16'h0010 ^ 16'h5a5a});
    for (int i = 0; i < 40 && q.size() > 0; i++) @(negedge I_CORE_CLK);
    if (q.size() > 0) n_mismatch++;
    tally_and_finish();
  end
endmodule : tb_secure_sector_cmd_decoder
